// [rtl/tpu_timer.sv]
// 16-bit timer/pwm unit with buffered modulo and channel value registers
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "tpu_defs.svh"
// Contract
// RQ1: with center-align set, software uses every active channel as center pwm.
// RQ2: modulo and channel value byte writes go to buffers first.
// RQ3: center mode, clock off: channel value loads when second byte written.
// RQ4: center mode, clock on: load on both bytes and count modulo-1 to modulo.
// RQ5: free-running counter: load when counter goes 0xfffe to 0xffff.
// RQ6: counter equal modulo sets overflow flag at end of that count.
// RQ7: main control write discards pending modulo buffer bytes.
// RQ8: channel control write discards that channel's pending value bytes.
// RQ9: any chip reset returns the whole unit to reset state.
// RQ10: reset clears main control: clock stopped, overflow interrupt off.
// RQ11: reset clears center-align, mode and edge bits: capture, pin released.
// RQ12: capture channel sets flag on each selected pin edge.
// RQ13: compare or pwm channel sets flag when counter matches value.
// RQ14: center mode counts zero up to modulo and back down, repeating.
module tpu_timer #(
  parameter int NCH     = 2,
  parameter int DIV_FIX = `TPU_DIV_DEFAULT
) (
  input  wire logic             CORE_CLK,
  input  wire logic             RST,
  input  wire logic [7:0]       ADDR,
  input  wire logic [7:0]       WDATA,
  input  wire logic             WR,
  input  wire logic             RD,
  output logic [7:0]            RDATA,
  input  wire logic             EXT_CLK,
  input  wire logic [NCH-1:0]   CH_PIN_IN,
  output logic [NCH-1:0]        CH_PIN_OUT,
  output logic [NCH-1:0]        CH_PIN_OE,
  output logic                  IRQ
);
  logic [7:0]       sc_r;
  logic [15:0]      cnt_r;
  logic [15:0]      mod_r;
  logic             down_r;
  logic [7:0]       div_r;
  logic [2:0]       ext_sync_r;
  logic             tick;
  logic             wr_sc;
  logic             ovf_evt;
  logic [15:0]      cnt_nxt;
  logic             down_nxt;
  logic [7:0]       csc_r  [NCH];
  logic [15:0]      cval_r [NCH];
  logic [NCH-1:0]   ch_evt;
  logic [NCH-1:0]   pin_s1_r;
  logic [NCH-1:0]   pin_s2_r;
  logic [NCH-1:0]   pin_d_r;
  logic [NCH:0]     irq_stat_r;
  logic [NCH:0]     irq_mask_r;
  logic [NCH:0]     evt_vec;
  logic             rd_stat;
  logic             cas;
  logic             clk_on;
  tpu_pkg::tpu_clk_t clk_sel;

  function automatic logic ch_hit(input logic [7:0] a, input int ch, input logic [1:0] r);
    ch_hit = (a == 8'(`TPU_OFF_CH_BASE + `TPU_CH_STRIDE * ch + r));
  endfunction

  assign cas     = sc_r[`TPU_SC_CAS];
  assign clk_sel = tpu_pkg::tpu_clk_t'({sc_r[`TPU_SC_CLKHI], sc_r[`TPU_SC_CLKLO]});
  assign clk_on  = (clk_sel != tpu_pkg::TPU_CLK_OFF);
  assign wr_sc   = WR && (ADDR == `TPU_OFF_SC);
  assign rd_stat = RD && (ADDR == `TPU_OFF_IRQ_STAT);

  // counter clock: bus rate, fixed divider, or synchronised external edge
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      div_r      <= 8'h00;
      ext_sync_r <= 3'b000;
    end else begin
      ext_sync_r <= {ext_sync_r[1:0], EXT_CLK};
      div_r      <= (div_r == 8'(DIV_FIX - 1)) ? 8'h00 : div_r + 8'h01;
    end
  end

  always_comb begin
    case (clk_sel)
      tpu_pkg::TPU_CLK_BUS:   tick = 1'b1;
      tpu_pkg::TPU_CLK_FIXED: tick = (div_r == 8'h00);
      tpu_pkg::TPU_CLK_EXT:   tick = ext_sync_r[1] && !ext_sync_r[2];
      default:                tick = 1'b0;
    endcase
  end

  // modulo buffer
  tpu_buf_if mod_bif ();
  assign mod_bif.wr_hi  = WR && (ADDR == `TPU_OFF_MODH); // RQ2
  assign mod_bif.wr_lo  = WR && (ADDR == `TPU_OFF_MODL); // RQ2
  assign mod_bif.wdata  = WDATA;
  assign mod_bif.cancel = wr_sc; // RQ7
  // modulo takes effect at once while stopped, else when the count at modulo (or 0xffff free-running) ends
  assign mod_bif.take   = mod_bif.full && !wr_sc && (!clk_on || (tick && ovf_evt));
  tpu_coh_buf u_mod_buf (.clk(CORE_CLK), .rst(RST), .bif(mod_bif.buffer));

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      mod_r <= `TPU_MOD_RESET; // RQ9
    end else if (mod_bif.take) begin
      mod_r <= mod_bif.value;
    end
  end

  // counter
  always_comb begin
    cnt_nxt  = cnt_r;
    down_nxt = down_r;
    ovf_evt  = 1'b0;
    if (cas) begin
      // RQ14: up to modulo, then down to zero
      if (!down_r) begin
        if (cnt_r >= mod_r) begin
          down_nxt = (mod_r != 16'h0000);
          cnt_nxt  = (mod_r != 16'h0000) ? mod_r - 16'h0001 : 16'h0000;
          ovf_evt  = 1'b1; // RQ6
        end else begin
          cnt_nxt = cnt_r + 16'h0001;
        end
      end else if (cnt_r == 16'h0000) begin
        down_nxt = 1'b0;
        cnt_nxt  = 16'h0001;
      end else begin
        cnt_nxt = cnt_r - 16'h0001;
      end
    end else begin
      down_nxt = 1'b0;
      if (mod_r != 16'h0000 && cnt_r == mod_r) begin
        cnt_nxt = 16'h0000;
        ovf_evt = 1'b1; // RQ6
      end else begin
        if (cnt_r == `TPU_CNT_FREE_TOP) ovf_evt = 1'b1; // RQ6
        cnt_nxt = cnt_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      cnt_r  <= 16'h0000;
      down_r <= 1'b0;
    end else if (WR && (ADDR == `TPU_OFF_CNTH || ADDR == `TPU_OFF_CNTL)) begin
      cnt_r  <= 16'h0000;
      down_r <= 1'b0;
    end else if (tick) begin
      cnt_r  <= cnt_nxt;
      down_r <= down_nxt;
    end
  end

  // main control; flag set wins over the software clear
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      sc_r <= `TPU_SC_RESET; // RQ10 RQ11
    end else begin
      if (wr_sc) begin
        sc_r[6:0] <= WDATA[6:0];
        if (!WDATA[`TPU_SC_OVF]) sc_r[`TPU_SC_OVF] <= 1'b0;
      end
      if (tick && ovf_evt) sc_r[`TPU_SC_OVF] <= 1'b1; // RQ6
    end
  end

  // channels
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_d_r  <= '0;
    end else begin
      pin_s1_r <= CH_PIN_IN;
      pin_s2_r <= pin_s1_r;
      pin_d_r  <= pin_s2_r;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      tpu_buf_if bif ();
      logic mode_out;
      logic rise;
      logic fall;
      logic load_pt;
      logic wr_csc;
      assign wr_csc    = WR && ch_hit(ADDR, g, `TPU_CH_SC);
      assign bif.wr_hi = WR && ch_hit(ADDR, g, `TPU_CH_VH); // RQ2
      assign bif.wr_lo = WR && ch_hit(ADDR, g, `TPU_CH_VL); // RQ2
      assign bif.wdata = WDATA;
      assign bif.cancel = wr_csc; // RQ8
      // RQ4 RQ5: step from modulo-1 to modulo in center mode, else count modulo, or 0xfffe when free-running
      assign load_pt = tick && (cas ? (!down_r && cnt_r == mod_r - 16'h0001)
                                    : ((mod_r == 16'h0000)
                                       ? (cnt_r == `TPU_CNT_FREE_PRE)
                                       : (cnt_r == mod_r)));
      assign bif.take = bif.full && !wr_csc && (!clk_on || load_pt); // RQ3 RQ4 RQ5
      tpu_coh_buf u_buf (.clk(CORE_CLK), .rst(RST), .bif(bif.buffer));

      assign mode_out = csc_r[g][`TPU_CSC_MSB] || csc_r[g][`TPU_CSC_MSA] || cas; // RQ1
      assign rise = pin_s2_r[g] && !pin_d_r[g];
      assign fall = !pin_s2_r[g] && pin_d_r[g];
      always_comb begin
        if (mode_out)
          ch_evt[g] = tick && (cnt_r == cval_r[g]); // RQ13
        else
          ch_evt[g] = (csc_r[g][`TPU_CSC_ELA] && rise) || (csc_r[g][`TPU_CSC_ELB] && fall); // RQ12
      end

      always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
          cval_r[g] <= 16'h0000;
        end else if (!mode_out && ch_evt[g]) begin
          cval_r[g] <= cnt_r;
        end else if (bif.take) begin
          cval_r[g] <= bif.value;
        end
      end

      always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
          csc_r[g] <= `TPU_CSC_RESET; // RQ11
        end else begin
          if (wr_csc) begin
            csc_r[g][6:0] <= WDATA[6:0];
            if (!WDATA[`TPU_CSC_FLAG]) csc_r[g][`TPU_CSC_FLAG] <= 1'b0;
          end
          if (ch_evt[g]) csc_r[g][`TPU_CSC_FLAG] <= 1'b1; // RQ12 RQ13
        end
      end

      // pwm: high while counter below value, low there with ELA set; pin released with edge bits clear
      always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
          CH_PIN_OUT[g] <= 1'b0;
          CH_PIN_OE[g]  <= 1'b0; // RQ11
        end else begin
          CH_PIN_OE[g]  <= mode_out && (csc_r[g][`TPU_CSC_ELB] || csc_r[g][`TPU_CSC_ELA]);
          CH_PIN_OUT[g] <= (cnt_r < cval_r[g]) ^ csc_r[g][`TPU_CSC_ELA];
        end
      end
      assign evt_vec[g+1] = ch_evt[g];
    end
  endgenerate
  assign evt_vec[0] = tick && ovf_evt;

  // sticky interrupt status, cleared by reading; a new event wins
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
    end else begin
      irq_stat_r <= (rd_stat ? '0 : irq_stat_r) | evt_vec;
      if (WR && ADDR == `TPU_OFF_IRQ_MASK) irq_mask_r <= WDATA[NCH:0];
    end
  end
  // overflow also gated by its own enable bit
  assign IRQ = |(irq_stat_r & irq_mask_r & {{NCH{1'b1}}, sc_r[`TPU_SC_OVIE]});

  // read port
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      RDATA <= 8'h00;
      case (ADDR)
        `TPU_OFF_SC:       RDATA <= sc_r;
        `TPU_OFF_CNTH:     RDATA <= cnt_r[15:8];
        `TPU_OFF_CNTL:     RDATA <= cnt_r[7:0];
        `TPU_OFF_MODH:     RDATA <= mod_r[15:8];
        `TPU_OFF_MODL:     RDATA <= mod_r[7:0];
        `TPU_OFF_IRQ_STAT: RDATA <= 8'(irq_stat_r);
        `TPU_OFF_IRQ_MASK: RDATA <= 8'(irq_mask_r);
        default: begin
          for (int c = 0; c < NCH; c++) begin
            if (ch_hit(ADDR, c, `TPU_CH_SC)) RDATA <= csc_r[c];
            if (ch_hit(ADDR, c, `TPU_CH_VH)) RDATA <= cval_r[c][15:8];
            if (ch_hit(ADDR, c, `TPU_CH_VL)) RDATA <= cval_r[c][7:0];
          end
        end
      endcase
    end
  end

  property p_rst_sc;
    @(posedge CORE_CLK) $rose(RST) |=> (sc_r == 8'h00);
  endproperty
  a_rst_sc: assert property (p_rst_sc) else $error("control not cleared by reset"); // RQ10

  property p_ovf;
    @(posedge CORE_CLK) disable iff (RST) (tick && ovf_evt && !wr_sc) |=> sc_r[`TPU_SC_OVF];
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag not set"); // RQ6

  property p_mod_cancel;
    @(posedge CORE_CLK) disable iff (RST) wr_sc |=> !mod_bif.full;
  endproperty
  a_mod_cancel: assert property (p_mod_cancel) else $error("modulo buffer kept"); // RQ7

  property p_mod_buffered;
    @(posedge CORE_CLK) disable iff (RST) (mod_bif.wr_hi && !mod_bif.full) |=> $stable(mod_r);
  endproperty
  a_mod_buffered: assert property (p_mod_buffered) else $error("modulo changed early"); // RQ2

  property p_ch0_cancel;
    @(posedge CORE_CLK) disable iff (RST) g_ch[0].wr_csc |=> !g_ch[0].bif.full;
  endproperty
  a_ch0_cancel: assert property (p_ch0_cancel) else $error("channel buffer kept"); // RQ8

  sequence s_ch0_pair_stopped;
    !clk_on && g_ch[0].bif.full && !g_ch[0].wr_csc;
  endsequence
  property p_ch0_load_now;
    @(posedge CORE_CLK) disable iff (RST)
      s_ch0_pair_stopped |=> (cval_r[0] == $past(g_ch[0].bif.value)) || $past(ch_evt[0]);
  endproperty
  a_ch0_load_now: assert property (p_ch0_load_now) else $error("value not loaded"); // RQ3

  property p_center_turn;
    @(posedge CORE_CLK) disable iff (RST)
      (cas && tick && !down_r && cnt_r == mod_r && mod_r != 16'h0000
       && !$changed(sc_r) && !mod_bif.take) |=> down_r;
  endproperty
  a_center_turn: assert property (p_center_turn) else $error("no turn at modulo"); // RQ14

  property p_ch_flag;
    @(posedge CORE_CLK) disable iff (RST) ch_evt[0] |=> csc_r[0][`TPU_CSC_FLAG];
  endproperty
  a_ch_flag: assert property (p_ch_flag) else $error("channel flag not set"); // RQ12

  // free-running pwm channel with a full pair, at the step to the top count
  sequence s_ch0_free_wrap;
    !cas && mod_r == 16'h0000 && tick && cnt_r == `TPU_CNT_FREE_PRE
      && g_ch[0].mode_out && g_ch[0].bif.full && !g_ch[0].wr_csc;
  endsequence
  property p_ch0_free_load;
    @(posedge CORE_CLK) disable iff (RST)
      s_ch0_free_wrap |=> (cval_r[0] == $past(g_ch[0].bif.value));
  endproperty
  a_ch0_free_load: assert property (p_ch0_free_load) else $error("value not loaded at wrap"); // RQ5

  property p_rst_oe;
    @(posedge CORE_CLK) $rose(RST) |=> (CH_PIN_OE == '0);
  endproperty
  a_rst_oe: assert property (p_rst_oe) else $error("pin enables not cleared by reset"); // RQ11
endmodule
`default_nettype wire

// [shared/tpu_defs.svh]
// register offsets, field positions, reset values and counts for the timer/pwm unit
`ifndef TPU_DEFS_SVH
`define TPU_DEFS_SVH
`define TPU_OFF_SC        8'h00
`define TPU_OFF_CNTH      8'h01
`define TPU_OFF_CNTL      8'h02
`define TPU_OFF_MODH      8'h03
`define TPU_OFF_MODL      8'h04
`define TPU_OFF_IRQ_STAT  8'h05
`define TPU_OFF_IRQ_MASK  8'h06
`define TPU_OFF_CH_BASE   8'h10
`define TPU_CH_STRIDE     8'h04
`define TPU_CH_SC         2'd0
`define TPU_CH_VH         2'd1
`define TPU_CH_VL         2'd2
`define TPU_CH_IN         2'd3
`define TPU_SC_OVF        7
`define TPU_SC_OVIE       6
`define TPU_SC_CAS        5
`define TPU_SC_CLKHI      4
`define TPU_SC_CLKLO      3
`define TPU_CSC_FLAG      7
`define TPU_CSC_IE        6
`define TPU_CSC_MSB       5
`define TPU_CSC_MSA       4
`define TPU_CSC_ELB       3
`define TPU_CSC_ELA       2
`define TPU_SC_RESET      8'h00
`define TPU_CSC_RESET     8'h00
`define TPU_MOD_RESET     16'h0000
`define TPU_CNT_FREE_PRE  16'hfffe
`define TPU_CNT_FREE_TOP  16'hffff
`define TPU_DIV_DEFAULT   8
`endif

// [shared/tpu_pkg.sv]
// types shared by the timer/pwm unit
package tpu_pkg;
  typedef enum logic [1:0] {
    TPU_COH_EMPTY,
    TPU_COH_HALF,
    TPU_COH_FULL
  } tpu_coh_t;
  typedef enum logic [1:0] {
    TPU_CLK_OFF,
    TPU_CLK_BUS,
    TPU_CLK_FIXED,
    TPU_CLK_EXT
  } tpu_clk_t;
endpackage

// [shared/tpu_buf_if.sv]
// write-buffer bundle between the unit and one coherency buffer
`timescale 1ns/10ps
`default_nettype none
interface tpu_buf_if;
  logic        wr_hi;
  logic        wr_lo;
  logic [7:0]  wdata;
  logic        cancel;
  logic        take;
  logic        full;
  logic [15:0] value;
  modport owner (output wr_hi, output wr_lo, output wdata, output cancel, output take,
                 input full, input value);
  modport buffer (input wr_hi, input wr_lo, input wdata, input cancel, input take,
                  output full, output value);
endinterface
`default_nettype wire

// [rtl/tpu_coh_buf.sv]
// two-byte write buffer with a coherency sequence
`timescale 1ns/10ps
`default_nettype none
module tpu_coh_buf (
  input  wire logic    clk,
  input  wire logic    rst,
  tpu_buf_if.buffer    bif
);
  tpu_pkg::tpu_coh_t state_r;
  logic [7:0]        hi_r;
  logic [7:0]        lo_r;

  // either byte first; the second completes the pair, take empties it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= tpu_pkg::TPU_COH_EMPTY;
    end else if (bif.cancel || bif.take) begin
      state_r <= tpu_pkg::TPU_COH_EMPTY;
    end else if (bif.wr_hi || bif.wr_lo) begin
      case (state_r)
        tpu_pkg::TPU_COH_EMPTY: state_r <= tpu_pkg::TPU_COH_HALF;
        tpu_pkg::TPU_COH_HALF:  state_r <= tpu_pkg::TPU_COH_FULL;
        tpu_pkg::TPU_COH_FULL:  state_r <= tpu_pkg::TPU_COH_FULL;
        default:                state_r <= tpu_pkg::TPU_COH_EMPTY;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hi_r <= 8'h00;
      lo_r <= 8'h00;
    end else begin
      if (bif.wr_hi) hi_r <= bif.wdata;
      if (bif.wr_lo) lo_r <= bif.wdata;
    end
  end

  assign bif.full  = (state_r == tpu_pkg::TPU_COH_FULL);
  assign bif.value = {hi_r, lo_r};
endmodule
`default_nettype wire

// [verification/tpu_pin_model.sv]
// behavioural model of what drives the channel pins and the external clock pin
`timescale 1ns/10ps
`default_nettype none
module tpu_pin_model #(
  parameter int NCH = 2,
  parameter int LAG = 6
) (
  input  wire logic           clk,
  output var  logic [NCH-1:0] pin,
  output var  logic           ext_clk
);
  // external clock stays low outside pulse bursts
  initial begin
    pin     = '0;
    ext_clk = 1'b0;
  end

  // a level change, then enough cycles for the two-flop synchroniser and edge detect
  task automatic drive(input int c, input logic v, input int extra = 0);
    @(posedge clk);
    pin[c] <= v;
    repeat (LAG + extra) @(posedge clk);
  endtask

  // each level lasts four cycles so the three-flop edge detect sees one rise per pulse
  task automatic ext_pulses(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      ext_clk <= 1'b1;
      repeat (4) @(posedge clk);
      ext_clk <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// [verification/tpu_timer_bench.sv]
// self-checking bench for the timer/pwm unit, driven over its register port
`timescale 1ns/10ps
`default_nettype none
module tpu_timer_bench;
  localparam int NCH = 2;
  logic           core_clk = 1'b0;
  logic           rst      = 1'b0;
  logic [7:0]     addr     = 8'h00;
  logic [7:0]     wdata    = 8'h00;
  logic           wr       = 1'b0;
  logic           rd       = 1'b0;
  logic [7:0]     rdata;
  logic           ext_clk;
  logic [NCH-1:0] pin_in;
  logic [NCH-1:0] pin_out;
  logic [NCH-1:0] pin_oe;
  logic           irq;
  int             n_fail   = 0;
  int             compares = 0;
  logic [7:0]     q;
  logic [7:0]     prev;
  logic           fell;

  always #2 core_clk = ~core_clk;

  tpu_timer #(.NCH(NCH), .DIV_FIX(2)) u_tpu_timer (
    .CORE_CLK  (core_clk),
    .RST       (rst),
    .ADDR      (addr),
    .WDATA     (wdata),
    .WR        (wr),
    .RD        (rd),
    .RDATA     (rdata),
    .EXT_CLK   (ext_clk),
    .CH_PIN_IN (pin_in),
    .CH_PIN_OUT(pin_out),
    .CH_PIN_OE (pin_oe),
    .IRQ       (irq)
  );

  tpu_pin_model #(.NCH(NCH)) u_tpu_pin_model (
    .clk    (core_clk),
    .pin    (pin_in),
    .ext_clk(ext_clk)
  );

  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge core_clk);
    wr    <= 1'b0;
  endtask

  // read data stand from the cycle after the strobe until the next read, so take them there
  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge core_clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string name);
    logic [7:0] v;
    rreg(a, v);
    chk(name, v, exp);
  endtask

  task automatic do_reset();
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  initial begin
    repeat (80000) @(posedge core_clk);
    n_fail++;
    test_done();
  end

  initial begin
    do_reset();
    rdc(8'h00, 8'h00, "control");
    rdc(8'h10, 8'h00, "ch0 control");
    rdc(8'h14, 8'h00, "ch1 control");
    chk("pin enables", {6'h00, pin_oe}, 8'h00);
    wreg(8'h08, 8'hff);
    rdc(8'h08, 8'h00, "unmapped");
    // modulo pair with the counter clock stopped
    wreg(8'h03, 8'h12);
    rdc(8'h03, 8'h00, "modulo hi pending");
    wreg(8'h00, 8'h00);
    wreg(8'h04, 8'h10);
    rdc(8'h04, 8'h00, "modulo lo after cancel");
    wreg(8'h03, 8'h00);
    rdc(8'h04, 8'h10, "modulo lo");
    rdc(8'h03, 8'h00, "modulo hi");
    // center mode: channel 0 is set up as center pwm, channel 1 is center pwm through center-align
    wreg(8'h00, 8'h20);
    wreg(8'h10, 8'h28);
    wreg(8'h11, 8'h01);
    rdc(8'h11, 8'h00, "ch0 value hi pending");
    wreg(8'h10, 8'h28);
    wreg(8'h12, 8'h08);
    rdc(8'h12, 8'h00, "ch0 value lo after cancel");
    wreg(8'h11, 8'h00);
    rdc(8'h12, 8'h08, "ch0 value lo");
    rdc(8'h11, 8'h00, "ch0 value hi");
    // run on the bus clock, overflow interrupt enabled, mask still closed
    wreg(8'h01, 8'h00);
    wreg(8'h00, 8'h68);
    wreg(8'h11, 8'h00);
    wreg(8'h12, 8'h0c);
    rdc(8'h12, 8'h08, "ch0 value held");
    fell = 1'b0;
    prev = 8'h00;
    for (int i = 0; i < 40; i++) begin
      rreg(8'h02, q);
      chk("counter above modulo", {7'h00, q > 8'h10}, 8'h00);
      if (q < prev) begin
        fell = 1'b1;
      end
      prev = q;
    end
    chk("counter turned down", {7'h00, fell}, 8'h01);
    rdc(8'h12, 8'h0c, "ch0 value loaded");
    rreg(8'h00, q);
    chk("overflow flag", q & 8'h80, 8'h80);
    rreg(8'h10, q);
    chk("ch0 match flag", q & 8'h80, 8'h80);
    chk("pin enables pwm", {6'h00, pin_oe}, 8'h01);
    chk("irq masked", {7'h00, irq}, 8'h00);
    wreg(8'h06, 8'h01);
    idle(2);
    chk("irq unmasked", {7'h00, irq}, 8'h01);
    wreg(8'h00, 8'h40);
    // channel 1 is also center pwm while center-align is set, and matches at zero
    rdc(8'h05, 8'h07, "irq status");
    idle(2);
    chk("irq after status read", {7'h00, irq}, 8'h00);
    rdc(8'h05, 8'h00, "irq status cleared");
    // stopped counter at zero: pwm high below the value, channel 1 value still zero
    wreg(8'h01, 8'h00);
    idle(2);
    chk("pwm outputs", {6'h00, pin_out}, 8'h01);
    // capture on channel 1: rising, then falling, then an edge not selected
    wreg(8'h14, 8'h04);
    u_tpu_pin_model.drive(1, 1'b1);
    rdc(8'h14, 8'h84, "ch1 rising capture");
    wreg(8'h14, 8'h08);
    u_tpu_pin_model.drive(1, 1'b0, 10);
    rdc(8'h14, 8'h88, "ch1 falling capture");
    wreg(8'h14, 8'h08);
    u_tpu_pin_model.drive(1, 1'b1);
    rdc(8'h14, 8'h08, "ch1 edge ignored");
    // second reset in mid-run
    wreg(8'h00, 8'h68);
    do_reset();
    rdc(8'h00, 8'h00, "control after reset");
    rdc(8'h04, 8'h00, "modulo after reset");
    rdc(8'h12, 8'h00, "ch0 value after reset");
    rdc(8'h10, 8'h00, "ch0 control after reset");
    chk("pin enables after reset", {6'h00, pin_oe}, 8'h00);
    chk("irq after reset", {7'h00, irq}, 8'h00);
    // free-running edge pwm: buffered value waits for the step to the top count
    wreg(8'h10, 8'h28);
    wreg(8'h00, 8'h08);
    wreg(8'h11, 8'h12);
    wreg(8'h12, 8'h34);
    idle(65500);
    rdc(8'h12, 8'h00, "ch0 value held before wrap");
    idle(40);
    rdc(8'h12, 8'h34, "ch0 value lo at wrap");
    rdc(8'h11, 8'h12, "ch0 value hi at wrap");
    rreg(8'h00, q);
    chk("free-run overflow flag", q & 8'h80, 8'h80);
    // modulo 3 on the external clock: flag only once the count at modulo ends
    wreg(8'h00, 8'h00);
    wreg(8'h03, 8'h00);
    wreg(8'h04, 8'h03);
    wreg(8'h00, 8'h18);
    wreg(8'h01, 8'h00);
    u_tpu_pin_model.ext_pulses(3);
    idle(4);
    rdc(8'h02, 8'h03, "external count");
    rreg(8'h00, q);
    chk("no overflow below modulo", q & 8'h80, 8'h00);
    u_tpu_pin_model.ext_pulses(1);
    idle(4);
    rdc(8'h02, 8'h00, "external wrap");
    rreg(8'h00, q);
    chk("overflow at modulo", q & 8'h80, 8'h80);
    // fixed divider of two: one count per two core cycles
    wreg(8'h00, 8'h10);
    rreg(8'h02, q);
    rreg(8'h02, prev);
    chk("fixed divider step", (prev - q) & 8'h03, 8'h01);
    test_done();
  end
endmodule
`default_nettype wire
